/* File: rtl/afe_cfg_pkg.sv */
// constants for the front-end configuration register bank (0eh..17h)
// assumes a 7-bit register address (compared zero-extended to 8 bits) and 8-bit data path from the serial decoder
package afe_cfg_pkg;

  // register offsets
  localparam logic [7:0] ADDR_DRIVE_NEG_SEL = 8'h0e;
  localparam logic [7:0] ADDR_SENSE_POS = 8'h0f;
  localparam logic [7:0] ADDR_SENSE_NEG = 8'h10;
  localparam logic [7:0] ADDR_CURRENT_REV = 8'h11;
  localparam logic [7:0] ADDR_STATUS_POS = 8'h12;
  localparam logic [7:0] ADDR_STATUS_NEG = 8'h13;
  localparam logic [7:0] ADDR_GENERAL_IO = 8'h14;
  localparam logic [7:0] ADDR_SPIKE_ROUTE = 8'h15;
  localparam logic [7:0] ADDR_BREATHING = 8'h16;
  localparam logic [7:0] ADDR_CONFIG_FOUR = 8'h17;

  // reset values
  localparam logic [7:0] RST_CHAN_REG = 8'h00;
  localparam logic [3:0] RST_PORT_DIR = 4'hf;
  localparam logic [3:0] RST_PORT_DATA = 4'h0;
  localparam logic [7:0] RST_SPIKE_ROUTE = 8'h00;
  localparam logic [7:0] RST_BREATHING = 8'h00;
  localparam logic [7:0] RST_CONFIG_FOUR = 8'h00;

  // general io field positions
  localparam int PORT_DATA_LSB = 4;
  localparam int PORT_DIR_LSB = 0;
  localparam int PORT_PINS = 4;

  // spike route field positions
  localparam int SPIKE_EVEN_LSB = 3;
  localparam int SPIKE_ODD_LSB = 1;
  localparam int SPIKE_BUF_BIT = 0;
  localparam logic [7:0] SPIKE_WRITE_MASK = 8'h1f;

  // breathing control field positions
  localparam int BR_DEMOD_BIT = 7;
  localparam int BR_MOD_BIT = 6;
  localparam int BR_RSVD_BIT = 5;
  localparam int BR_PHASE_LSB = 2;
  localparam int BR_MODE_LSB = 0;

  // config four field positions
  localparam int C4_FREQ_LSB = 5;
  localparam int C4_SINGLE_BIT = 3;
  localparam int C4_CT_DRIVE_BIT = 2;
  localparam int C4_COMP_BIT = 1;
  localparam logic [7:0] C4_WRITE_MASK = 8'hee;

  // breathing modes
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_EXTERNAL = 2'b01,
    MODE_INT_SIGNALS = 2'b10,
    MODE_INT_USER = 2'b11
  } breathing_mode_t;

  localparam logic [2:0] PHASE_NOT_APPLICABLE = 3'h7;

  // serial word assembly
  localparam int SERIAL_BITS = 8;

endpackage : afe_cfg_pkg

/* File: rtl/afe_cfg_regs.sv */
// configuration and status bank for a multichannel biopotential front-end,
// reached through a four-wire serial port (mode 0: sample on rising edge).
// assumes the link clock is far slower than CLK_SYS and is sampled by it.
// serial frame: byte 0 = {rw, 7-bit address}, byte 1 = data (rw=1 read).
`timescale 1ns/100ps
module afe_cfg_regs
  import afe_cfg_pkg::*;
#(
  parameter int CHANNELS = 8, // 4, 6 or 8
  parameter bit HAS_BREATHING = 1'b1 // breathing-capable variant
) (
  // clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // serial peripheral link
  input wire logic SEL_N,
  input wire logic SCLK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  // electrode detach comparators
  input wire logic [7:0] POS_DETACHED,
  input wire logic [7:0] NEG_DETACHED,
  // general purpose port pins
  input wire logic [3:0] PORT_IN,
  output logic [3:0] PORT_OUT,
  output logic [3:0] PORT_OE,
  // analog controls
  output logic [7:0] DRIVE_NEG_SELECT,
  output logic [7:0] DETACH_SENSE_POS,
  output logic [7:0] DETACH_SENSE_NEG,
  output logic [7:0] DETACH_CURRENT_REV,
  output logic [3:0] SPIKE_ONE_CHANNEL,
  output logic [3:0] SPIKE_TWO_CHANNEL,
  output logic SPIKE_BUFFER_ON,
  output logic BREATHING_DEMOD_ON,
  output logic BREATHING_MOD_ON,
  output logic [2:0] BREATHING_PHASE_SEL,
  output logic BREATHING_PHASE_VALID,
  output logic [1:0] BREATHING_MODE_SEL,
  output logic PORT_PINS_TAKEN,
  output logic [2:0] BREATHING_FREQ_SEL,
  output logic SINGLE_CONVERSION,
  output logic CENTRAL_TERMINAL_TO_DRIVE,
  output logic DETACH_COMPARATOR_ON
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // mask of channel bits that exist on this variant
  function automatic logic [7:0] chan_mask(input int n);
    logic [7:0] m;
    m = 8'hff;
    if (n <= 6) m[7:6] = 2'b00;
    if (n <= 4) m[5:4] = 2'b00;
    return m;
  endfunction : chan_mask

  localparam logic [7:0] CH_MASK = chan_mask(CHANNELS);

  ////////////////////////////////////////////////////////////////////////////
  // synchronise link pins and port inputs

  logic sel_n_s; // synchronised select
  logic sclk_rise; // sample edge for input
  logic sclk_fall; // shift edge for output
  logic sdi_s; // synchronised data in
  logic [3:0] port_in_s; // synchronised pin levels

  edge_sync u_sel (
    .clk(CLK_SYS), .rst(RST), .ce(CE), .async_in(SEL_N),
    .level(sel_n_s), .rise(), .fall()
  );
  edge_sync u_sclk (
    .clk(CLK_SYS), .rst(RST), .ce(CE), .async_in(SCLK),
    .level(), .rise(sclk_rise), .fall(sclk_fall)
  );
  edge_sync u_sdi (
    .clk(CLK_SYS), .rst(RST), .ce(CE), .async_in(SDI),
    .level(sdi_s), .rise(), .fall()
  );

  // pin levels pass the same two-stage path as the link
  genvar gi;
  generate
    for (gi = 0; gi < PORT_PINS; gi++) begin : g_pin
      edge_sync u_pin (
        .clk(CLK_SYS), .rst(RST), .ce(CE), .async_in(PORT_IN[gi]),
        .level(port_in_s[gi]), .rise(), .fall()
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // serial framing; sdi is aligned with sclk, so the rising sample lags the
  // pin by two cycles, well inside a 160 ns link period

  logic [2:0] bit_cnt_r; // bit within byte
  logic byte_idx_r; // 0 = command byte, 1 = data byte
  logic [7:0] shift_in_r; // incoming bits
  logic is_read_r; // current frame reads
  logic [6:0] addr_r; // current frame address
  logic frame_done_r; // one data byte handled, ignore the rest
  logic [7:0] shift_out_r; // outgoing bits
  logic wr_stb; // write strobe this cycle
  logic [7:0] wr_data; // write data this cycle
  logic cmd_done; // command byte just completed
  logic [7:0] in_byte; // byte including current bit

  assign in_byte = {shift_in_r[6:0], sdi_s};
  assign cmd_done = sclk_rise && !sel_n_s && bit_cnt_r == 3'h7 && !byte_idx_r;
  assign wr_stb = sclk_rise && !sel_n_s && bit_cnt_r == 3'h7 && byte_idx_r
                  && !is_read_r && !frame_done_r;
  assign wr_data = in_byte;

  // bit and byte counting; select high resets the frame
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bit_cnt_r <= 3'h0;
      byte_idx_r <= 1'b0;
      shift_in_r <= 8'h00;
      is_read_r <= 1'b0;
      addr_r <= 7'h00;
      frame_done_r <= 1'b0;
    end else if (CE) begin
      if (sel_n_s) begin
        bit_cnt_r <= 3'h0;
        byte_idx_r <= 1'b0;
        frame_done_r <= 1'b0;
      end else if (sclk_rise) begin
        shift_in_r <= in_byte;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7) begin
          if (!byte_idx_r) begin
            is_read_r <= in_byte[7];
            addr_r <= in_byte[6:0];
            byte_idx_r <= 1'b1;
          end else begin
            frame_done_r <= 1'b1; // extra bytes are ignored
          end
        end
      end
    end
  end

  // output shifter: loads read data after the command, shifts on falling edge
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      shift_out_r <= 8'h00;
      SDO <= 1'b0;
      SDO_OE <= 1'b0;
    end else if (CE) begin
      SDO_OE <= !sel_n_s && byte_idx_r && is_read_r && !frame_done_r;
      if (sel_n_s) begin
        shift_out_r <= 8'h00;
        SDO <= 1'b0;
      end else if (cmd_done) begin
        shift_out_r <= in_byte[7] ? rd_data_of(in_byte[6:0]) : 8'h00;
      end else if (sclk_fall && byte_idx_r) begin
        SDO <= shift_out_r[7];
        shift_out_r <= {shift_out_r[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] drive_neg_r; // 0eh
  logic [7:0] sense_pos_r; // 0fh
  logic [7:0] sense_neg_r; // 10h
  logic [7:0] cur_rev_r; // 11h
  logic [7:0] stat_pos_r; // 12h captured comparator state
  logic [7:0] stat_neg_r; // 13h
  logic [7:0] stat_pos_meta_r; // first stage of positive comparator levels
  logic [7:0] stat_neg_meta_r; // first stage of negative comparator levels
  logic [3:0] port_data_r; // 14h[7:4] written levels
  logic [3:0] port_dir_r; // 14h[3:0]
  logic [7:0] spike_r; // 15h
  logic [7:0] breathing_r; // 16h
  logic [7:0] config_four_r; // 17h
  logic [3:0] pin_taken; // pins held by breathing mode

  // per-channel writes; absent channels stay zero
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      drive_neg_r <= RST_CHAN_REG;
      sense_pos_r <= RST_CHAN_REG;
      sense_neg_r <= RST_CHAN_REG;
      cur_rev_r <= RST_CHAN_REG;
    end else if (CE && wr_stb) begin
      case ({1'b0, addr_r})
        ADDR_DRIVE_NEG_SEL: drive_neg_r <= wr_data & CH_MASK;
        ADDR_SENSE_POS: sense_pos_r <= wr_data & CH_MASK;
        ADDR_SENSE_NEG: sense_neg_r <= wr_data & CH_MASK;
        ADDR_CURRENT_REV: cur_rev_r <= wr_data & CH_MASK;
        default: ;
      endcase
    end
  end

  // status passes two stages every cycle; the host alone decides validity via enables
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      stat_pos_meta_r <= 8'h00;
      stat_neg_meta_r <= 8'h00;
      stat_pos_r <= 8'h00;
      stat_neg_r <= 8'h00;
    end else if (CE) begin
      stat_pos_meta_r <= POS_DETACHED;
      stat_neg_meta_r <= NEG_DETACHED;
      stat_pos_r <= stat_pos_meta_r;
      stat_neg_r <= stat_neg_meta_r;
    end
  end

  // general io port register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      port_data_r <= RST_PORT_DATA;
      port_dir_r <= RST_PORT_DIR;
    end else if (CE && wr_stb && {1'b0, addr_r} == ADDR_GENERAL_IO) begin
      port_dir_r <= wr_data[PORT_DIR_LSB +: PORT_PINS];
      // only output pins take the written level
      for (int i = 0; i < PORT_PINS; i++) begin
        if (!wr_data[PORT_DIR_LSB + i]) begin
          port_data_r[i] <= wr_data[PORT_DATA_LSB + i];
        end
      end
    end
  end

  // spike routing, breathing and config four
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      spike_r <= RST_SPIKE_ROUTE;
      breathing_r <= RST_BREATHING;
      config_four_r <= RST_CONFIG_FOUR;
    end else if (CE && wr_stb) begin
      case ({1'b0, addr_r})
        ADDR_SPIKE_ROUTE: spike_r <= wr_data & SPIKE_WRITE_MASK;
        ADDR_BREATHING: breathing_r <= wr_data;
        ADDR_CONFIG_FOUR: config_four_r <= wr_data & C4_WRITE_MASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode, shared by the frame loader

  function automatic logic [7:0] rd_data_of(input logic [6:0] a);
    case ({1'b0, a})
      ADDR_DRIVE_NEG_SEL: rd_data_of = drive_neg_r;
      ADDR_SENSE_POS: rd_data_of = sense_pos_r;
      ADDR_SENSE_NEG: rd_data_of = sense_neg_r;
      ADDR_CURRENT_REV: rd_data_of = cur_rev_r;
      ADDR_STATUS_POS: rd_data_of = stat_pos_r & CH_MASK;
      ADDR_STATUS_NEG: rd_data_of = stat_neg_r & CH_MASK;
      ADDR_GENERAL_IO: rd_data_of = {port_in_s, port_dir_r};
      ADDR_SPIKE_ROUTE: rd_data_of = spike_r;
      ADDR_BREATHING: rd_data_of = breathing_r;
      ADDR_CONFIG_FOUR: rd_data_of = config_four_r;
      default: rd_data_of = 8'h00; // registers outside this bank
    endcase
  endfunction : rd_data_of

  ////////////////////////////////////////////////////////////////////////////
  // derived controls

  breathing_mode_t mode; // current breathing mode
  logic [2:0] freq; // breathing frequency code

  assign mode = breathing_mode_t'(breathing_r[BR_MODE_LSB +: 2]);
  assign freq = config_four_r[C4_FREQ_LSB +: 3];

  // pins two to four belong to the breathing circuit in modes 01 and 11
  always_comb begin
    case (mode)
      MODE_EXTERNAL, MODE_INT_USER: pin_taken = 4'he;
      default: pin_taken = 4'h0;
    endcase
  end

  // port pin drive; taken pins are released from general use
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PORT_OUT <= 4'h0;
      PORT_OE <= 4'h0;
      PORT_PINS_TAKEN <= 1'b0;
    end else if (CE) begin
      PORT_OUT <= port_data_r & ~pin_taken;
      PORT_OE <= ~port_dir_r & ~pin_taken;
      PORT_PINS_TAKEN <= |pin_taken;
    end
  end

  // channel controls; spike selects decoded to channel numbers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      DRIVE_NEG_SELECT <= 8'h00;
      DETACH_SENSE_POS <= 8'h00;
      DETACH_SENSE_NEG <= 8'h00;
      DETACH_CURRENT_REV <= 8'h00;
      SPIKE_ONE_CHANNEL <= 4'h2;
      SPIKE_TWO_CHANNEL <= 4'h1;
      SPIKE_BUFFER_ON <= 1'b0;
    end else if (CE) begin
      DRIVE_NEG_SELECT <= drive_neg_r;
      DETACH_SENSE_POS <= sense_pos_r;
      DETACH_SENSE_NEG <= sense_neg_r;
      DETACH_CURRENT_REV <= cur_rev_r;
      SPIKE_ONE_CHANNEL <= {1'b0, spike_r[SPIKE_EVEN_LSB +: 2], 1'b0} + 4'h2;
      SPIKE_TWO_CHANNEL <= {1'b0, spike_r[SPIKE_ODD_LSB +: 2], 1'b1};
      SPIKE_BUFFER_ON <= spike_r[SPIKE_BUF_BIT];
    end
  end

  // breathing and conversion controls; non-breathing variants hold only the demod and mod enables off
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      BREATHING_DEMOD_ON <= 1'b0;
      BREATHING_MOD_ON <= 1'b0;
      BREATHING_PHASE_SEL <= 3'h0;
      BREATHING_PHASE_VALID <= 1'b0;
      BREATHING_MODE_SEL <= 2'b00;
      BREATHING_FREQ_SEL <= 3'h0;
      SINGLE_CONVERSION <= 1'b0;
      CENTRAL_TERMINAL_TO_DRIVE <= 1'b0;
      DETACH_COMPARATOR_ON <= 1'b0;
    end else if (CE) begin
      BREATHING_DEMOD_ON <= HAS_BREATHING & breathing_r[BR_DEMOD_BIT];
      BREATHING_MOD_ON <= HAS_BREATHING & breathing_r[BR_MOD_BIT];
      BREATHING_PHASE_SEL <= breathing_r[BR_PHASE_LSB +: 3];
      // phase counts only in modes 10/01 at the two lowest frequencies
      BREATHING_PHASE_VALID <= (mode == MODE_EXTERNAL || mode == MODE_INT_SIGNALS)
                               && freq[2:1] == 2'b00
                               && breathing_r[BR_PHASE_LSB +: 3] != PHASE_NOT_APPLICABLE;
      BREATHING_MODE_SEL <= mode;
      BREATHING_FREQ_SEL <= freq;
      SINGLE_CONVERSION <= config_four_r[C4_SINGLE_BIT];
      CENTRAL_TERMINAL_TO_DRIVE <= config_four_r[C4_CT_DRIVE_BIT];
      DETACH_COMPARATOR_ON <= config_four_r[C4_COMP_BIT];
    end
  end

endmodule : afe_cfg_regs

/* File: rtl/edge_sync.sv */
// two-flop synchroniser with edge detection for one external level
// assumes input is asynchronous to clk; edges are derived from the second stage
`timescale 1ns/100ps
module edge_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // asynchronous level in
  input wire logic async_in,
  // synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_r; // first stage, read only by the second stage
  logic sync_r; // second stage
  logic prev_r; // delayed copy for edge finding

  // two stages then one history flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  // edges qualified by enable so a frozen block sees none
  assign rise = ce & sync_r & ~prev_r;
  assign fall = ce & ~sync_r & prev_r;

endmodule : edge_sync

/* File: verif/afe_cfg_regs_props.sv */
// port-level checker for the configuration and status bank
// assumes one clock domain and that all register writes happen inside frames
`timescale 1ns/100ps
module afe_cfg_regs_props
  import afe_cfg_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter bit HAS_BREATHING = 1'b1
) (
  // clock, reset, enable
  input wire logic CLK_SYS, RST, CE,
  // serial link
  input wire logic SEL_N, SCLK, SDI, SDO, SDO_OE,
  // comparators and port pins
  input wire logic [7:0] POS_DETACHED, NEG_DETACHED,
  input wire logic [3:0] PORT_IN, PORT_OUT, PORT_OE,
  // analog controls
  input wire logic [7:0] DRIVE_NEG_SELECT, DETACH_SENSE_POS, DETACH_SENSE_NEG,
    DETACH_CURRENT_REV,
  input wire logic [3:0] SPIKE_ONE_CHANNEL, SPIKE_TWO_CHANNEL,
  input wire logic SPIKE_BUFFER_ON, BREATHING_DEMOD_ON, BREATHING_MOD_ON,
  input wire logic [2:0] BREATHING_PHASE_SEL,
  input wire logic BREATHING_PHASE_VALID,
  input wire logic [1:0] BREATHING_MODE_SEL,
  input wire logic PORT_PINS_TAKEN,
  input wire logic [2:0] BREATHING_FREQ_SEL,
  input wire logic SINGLE_CONVERSION, CENTRAL_TERMINAL_TO_DRIVE, DETACH_COMPARATOR_ON
);
  // one domain, so clock and disable are given once
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  // first edge after release must still show the documented defaults
  a_reset_values: assert property ($fell(RST) |-> SPIKE_ONE_CHANNEL == 4'h2 &&
    SPIKE_TWO_CHANNEL == 4'h1 && PORT_OE == 4'h0 && !SPIKE_BUFFER_ON &&
    BREATHING_MODE_SEL == 2'h0 && !DETACH_COMPARATOR_ON && !SINGLE_CONVERSION)
    else $error("reset defaults wrong");
  // modes 01 and 11 claim the shared pins
  a_taken_mode: assert property (PORT_PINS_TAKEN == BREATHING_MODE_SEL[0])
    else $error("pin takeover does not follow mode");
  a_taken_undriven: assert property (PORT_PINS_TAKEN |-> PORT_OE[3:1] == 3'h0)
    else $error("taken pins still driven");
  // phase only meaningful in modes 01/10 with the two low frequencies
  a_phase_valid: assert property (BREATHING_PHASE_VALID ==
    ((BREATHING_MODE_SEL inside {2'b01, 2'b10}) && BREATHING_FREQ_SEL <= 3'h1 &&
    BREATHING_PHASE_SEL != 3'h7))
    else $error("phase valid flag wrong");
  a_spike_even: assert property (SPIKE_ONE_CHANNEL inside {4'h2, 4'h4, 4'h6, 4'h8})
    else $error("even spike channel not even");
  a_spike_odd: assert property (SPIKE_TWO_CHANNEL inside {4'h1, 4'h3, 4'h5, 4'h7})
    else $error("odd spike channel not odd");
  // nothing may move while the link is idle: writes only land in frames
  a_port_hold: assert property (SEL_N [*4] |=> $stable(PORT_OE) && $stable(PORT_OUT))
    else $error("port drive moved while idle");
  a_chan_hold: assert property (SEL_N [*4] |=> $stable(DRIVE_NEG_SELECT) &&
    $stable(DETACH_SENSE_POS) && $stable(DETACH_SENSE_NEG) &&
    $stable(DETACH_CURRENT_REV))
    else $error("channel control moved while idle");
  a_cfg_hold: assert property (SEL_N [*4] |=> $stable(BREATHING_FREQ_SEL) &&
    $stable(SINGLE_CONVERSION) && $stable(DETACH_COMPARATOR_ON) &&
    $stable(CENTRAL_TERMINAL_TO_DRIVE))
    else $error("config four moved while idle");
  a_breath_hold: assert property (SEL_N [*4] |=> $stable(BREATHING_DEMOD_ON) &&
    $stable(BREATHING_MOD_ON) && $stable(BREATHING_MODE_SEL))
    else $error("breathing control moved while idle");
  // a deselected device lets go of its data line
  a_sdo_release: assert property ((SEL_N && CE) [*3] |=> !SDO_OE)
    else $error("data line driven while deselected");
endmodule : afe_cfg_regs_props

bind afe_cfg_regs afe_cfg_regs_props #(.CHANNELS(CHANNELS), .HAS_BREATHING(HAS_BREATHING))
  u_props (.*);

/* File: verif/spi_host_model.sv */
// host side of the serial link: frames of {rw, address} then one data byte
// assumes clk is the bench system clock; SCLK runs 160 ns only inside frames
`timescale 1ns/100ps
module spi_host_model (
  // clock
  input wire logic clk,
  // link
  output logic sel_n,
  output logic sclk,
  output wire logic sdi,
  input wire logic sdo,
  // read result towards the bench
  output logic rd_valid,
  output logic [7:0] rd_data
);
  logic drv; // high while the host owns the data line
  logic sdi_q; // bit being presented
  logic tgl = 1'b0; // moving pattern on a released line
  ////////////////////////////////////////////////////////////////////////////
  // released line toggles so a stale level never reads as valid
  always @(posedge clk) tgl <= ~tgl;
  assign sdi = drv ? sdi_q : tgl;
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    drv = 1'b0;
    sdi_q = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one whole frame; data changes with clock low, sampled on rising
  task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] w;
    logic [7:0] q;
    w = {rw, a, d};
    q = 8'h00;
    @(posedge clk);
    sel_n <= 1'b0;
    drv <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      sdi_q <= w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      if (i < 8) q = {q[6:0], sdo};
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    // let the last write land before deselecting
    repeat (4) @(posedge clk);
    sel_n <= 1'b1;
    drv <= 1'b0;
    if (rw) begin
      rd_data <= q;
      rd_valid <= 1'b1;
      @(posedge clk);
      rd_valid <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask : frame
endmodule : spi_host_model

/* File: verif/tb_afe_cfg_regs.sv */
// self-checking bench for the configuration bank, host model on the link
// assumes the full eight-channel breathing-capable variant
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_afe_cfg_regs
  import afe_cfg_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic sel_n, sclk, sdi, sdo, sdo_oe, rd_valid, sp_buf, demod, modu, ph_ok, taken;
  logic single, ct, comp;
  logic [7:0] pos_det = 8'h00, neg_det = 8'h00, rd_data, drv_neg, s_pos, s_neg, c_rev;
  logic [3:0] pin_ext = 4'h0, port_out, port_oe, sp1, sp2;
  logic [2:0] phase, freq;
  logic [1:0] mode;
  wire logic [3:0] port_in = (port_oe & port_out) | (~port_oe & pin_ext); // resolved pins
  logic [7:0] exp_q[$]; // expected read data, oldest first
  int miscompares = 0, total_checks = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  afe_cfg_regs #(.CHANNELS(8), .HAS_BREATHING(1'b1)) dut (.CLK_SYS(clk), .RST(rst),
    .CE(ce), .SEL_N(sel_n), .SCLK(sclk), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe),
    .POS_DETACHED(pos_det), .NEG_DETACHED(neg_det), .PORT_IN(port_in),
    .PORT_OUT(port_out), .PORT_OE(port_oe), .DRIVE_NEG_SELECT(drv_neg),
    .DETACH_SENSE_POS(s_pos), .DETACH_SENSE_NEG(s_neg), .DETACH_CURRENT_REV(c_rev),
    .SPIKE_ONE_CHANNEL(sp1), .SPIKE_TWO_CHANNEL(sp2), .SPIKE_BUFFER_ON(sp_buf),
    .BREATHING_DEMOD_ON(demod), .BREATHING_MOD_ON(modu), .BREATHING_PHASE_SEL(phase),
    .BREATHING_PHASE_VALID(ph_ok), .BREATHING_MODE_SEL(mode), .PORT_PINS_TAKEN(taken),
    .BREATHING_FREQ_SEL(freq), .SINGLE_CONVERSION(single),
    .CENTRAL_TERMINAL_TO_DRIVE(ct), .DETACH_COMPARATOR_ON(comp));
  spi_host_model host (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .rd_valid(rd_valid), .rd_data(rd_data));
  ////////////////////////////////////////////////////////////////////////////
  // register access through the link
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.frame(1'b0, a[6:0], d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.frame(1'b1, a[6:0], 8'h00);
  endtask : rd
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // watcher: every returned read is matched to the oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(rd_data, 8'hxx)
      else `CHK(rd_data, exp_q.pop_front())
    end
  end
  // hang guard, well above the expected run of about 20k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v, c, d, cv[4];
    logic [2:0] f;
    void'($urandom(50));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    pin_ext <= 4'h5;
    repeat (6) @(posedge clk);
    // defaults, with unmapped neighbours 0dh and 18h
    `CHK(sp1, 4'h2)
    `CHK(sp2, 4'h1)
    `CHK(port_oe, 4'h0)
    for (int a = 'h0d; a <= 'h18; a++) rd(8'(a), a == 'h14 ? 8'h5f : 8'h00);
    $display("test defaults done");
    // live status; status writes refused; host enables sensing first
    v = 8'($urandom);
    c = 8'($urandom);
    pos_det <= v;
    neg_det <= c;
    wr(ADDR_SENSE_POS, 8'hff);
    wr(ADDR_STATUS_POS, ~v);
    rd(ADDR_STATUS_POS, v);
    wr(ADDR_STATUS_NEG, ~c);
    rd(ADDR_STATUS_NEG, c);
    $display("test status done");
    // channel registers keep and drive what was written
    for (int i = 0; i < 4; i++) begin
      cv[i] = 8'($urandom);
      wr(ADDR_DRIVE_NEG_SEL + 8'(i), cv[i]);
      rd(ADDR_DRIVE_NEG_SEL + 8'(i), cv[i]);
    end
    `CHK({drv_neg, s_pos, s_neg, c_rev}, {cv[0], cv[1], cv[2], cv[3]})
    $display("test channels done");
    // pins 3,2 output, 1,0 input: data bit 1 must be ignored
    wr(ADDR_GENERAL_IO, 8'ha3);
    `CHK(port_oe, 4'hc)
    `CHK(port_out, 4'h8)
    rd(ADDR_GENERAL_IO, 8'h93);
    $display("test port done");
    // every even/odd route code and buffer state; top bits refused
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_SPIKE_ROUTE, {3'b111, 5'(i)});
      rd(ADDR_SPIKE_ROUTE, {3'b000, 5'(i)});
      `CHK(sp1, 4'(2 * (i / 8) + 2))
      `CHK(sp2, 4'(2 * ((i / 2) % 4) + 1))
      `CHK(sp_buf, 1'(i))
    end
    $display("test spike done");
    // every mode against three frequencies, random phase and enables
    for (int i = 0; i < 12; i++) begin
      f = (i < 4) ? 3'h0 : (i < 8) ? 3'h1 : 3'h5;
      c = {f, 5'($urandom) | 5'h11};
      v = 8'($urandom);
      d = {v[7:6], 1'b1, ((i == 5) ? 3'h7 : v[4:2]), 2'(i)};
      wr(ADDR_CONFIG_FOUR, c);
      wr(ADDR_BREATHING, d);
      rd(ADDR_BREATHING, d);
      rd(ADDR_CONFIG_FOUR, c & 8'hee);
      `CHK({demod, modu, phase, mode}, {d[7:6], d[4:0]})
      `CHK(taken, d[0])
      `CHK(port_oe, d[0] ? 4'h0 : 4'hc)
      `CHK(ph_ok, (d[1] ^ d[0]) && f < 3'h2 && d[4:2] != 3'h7)
      `CHK({freq, single, ct}, {f, c[3:2]})
      `CHK(comp, c[1])
    end
    $display("test breathing done");
    // a frame sent with the enable low is never seen
    ce <= 1'b0;
    wr(ADDR_SPIKE_ROUTE, 8'h00);
    ce <= 1'b1;
    rd(ADDR_SPIKE_ROUTE, 8'h1f);
    // reset in mid-run brings back the defaults
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({sp1, sp2, sp_buf, port_oe}, {4'h2, 4'h1, 1'b0, 4'h0})
    rd(ADDR_GENERAL_IO, 8'h5f);
    $display("test freeze and reset done");
    tally_and_finish();
  end
endmodule : tb_afe_cfg_regs
